/* File: src/bscr_pkg.sv */
package bscr_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] BUS_NUM_OFFSET = 8'h18;
    localparam logic [7:0] IO_STATUS_OFFSET = 8'h1c;
    localparam logic [7:0] INT_STATUS_OFFSET = 8'h40;
    localparam logic [7:0] INT_MASK_OFFSET = 8'h44;
    localparam logic [7:0] CONTROL_OFFSET = 8'h48;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int SEC_BUS_LSB = 8;
    localparam int HIGH_BUS_LSB = 16;
    localparam int LAT_TIMER_LSB = 24;
    localparam int IO_BASE_LSB = 4;
    localparam int IO_LIMIT_LSB = 12;
    localparam int IO_BASE_CAP_LSB = 0;
    localparam int IO_LIMIT_CAP_LSB = 8;
    localparam int CAP_66MHZ_BIT = 21;
    localparam int FAST_B2B_BIT = 23;
    localparam int MDPE_BIT = 24;
    localparam int CTRL_REVERSE_BIT = 0;
    localparam int CTRL_PARALLEL_BIT = 1;
    localparam int CTRL_PERR_EN_BIT = 2;
    // ****************************************************************
    // reset and fixed values
    // ****************************************************************
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] WINDOW_RESET = 4'h0;
    localparam logic [1:0] IO_32BIT_CODE = 2'h1;
    localparam logic [2:0] CONTROL_RESET = 3'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int NUM_EVENTS = 5;
endpackage : bscr_pkg

/* File: src/bscr_regs.sv */
module bscr_regs (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic READ_DATA_PARITY_ERROR,
    input wire logic WRITE_PHASE_ACTIVE,
    input wire logic DOWNSTREAM_PARITY_ERROR_N,
    input wire logic SPLIT_MSG_PARITY_ERROR,
    input wire logic POISONED_COMPLETION,
    input wire logic POISONED_WRITE_FORWARDED,
    output logic [7:0] SECONDARY_BUS_NUMBER,
    output logic [7:0] HIGHEST_DOWNSTREAM_BUS,
    output logic [7:0] SECONDARY_LATENCY_TIMER,
    output logic [3:0] IO_WINDOW_BASE,
    output logic [3:0] IO_WINDOW_LIMIT,
    output logic MASTER_PARITY_ERROR,
    output logic IRQ
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] sec_bus;
        logic [7:0] high_bus;
        logic [7:0] lat_timer;
        logic [3:0] io_base;
        logic [3:0] io_limit;
        logic mdpe;
        logic [2:0] control;
        logic [bscr_pkg::NUM_EVENTS-1:0] int_status;
        logic [bscr_pkg::NUM_EVENTS-1:0] int_mask;
        logic irq;
        logic aw_ready;
        logic w_ready;
        logic ar_ready;
    } bscr_state_t;

    bscr_state_t r;
    bscr_state_t next_r;

    logic reverse;
    logic parallel;
    logic perr_en;
    logic [bscr_pkg::NUM_EVENTS-1:0] ev;
    logic any_set;
    logic do_write;
    logic do_read;
    logic [31:0] wd;
    logic [31:0] rd;
    logic rd_hit;
    logic wr_hit;

    assign reverse = r.control[bscr_pkg::CTRL_REVERSE_BIT];
    assign parallel = r.control[bscr_pkg::CTRL_PARALLEL_BIT];
    assign perr_en = r.control[bscr_pkg::CTRL_PERR_EN_BIT];

    // ****************************************************************
    // parity event sources
    // ****************************************************************
    assign ev[0] = !reverse && READ_DATA_PARITY_ERROR;
    assign ev[1] = !reverse && WRITE_PHASE_ACTIVE
        && !DOWNSTREAM_PARITY_ERROR_N;
    assign ev[2] = !reverse && SPLIT_MSG_PARITY_ERROR;
    assign ev[3] = reverse && POISONED_COMPLETION;
    assign ev[4] = reverse && POISONED_WRITE_FORWARDED;
    assign any_set = perr_en && (|ev);

    // ****************************************************************
    // register read mux
    // ****************************************************************
    always_comb begin
        rd = 32'h0;
        rd_hit = 1'b1;
        case (S_AXI_ARADDR)
            bscr_pkg::BUS_NUM_OFFSET: begin
                rd[bscr_pkg::SEC_BUS_LSB +: 8] = r.sec_bus;
                rd[bscr_pkg::HIGH_BUS_LSB +: 8] = r.high_bus;
                rd[bscr_pkg::LAT_TIMER_LSB +: 8] = r.lat_timer;
            end
            bscr_pkg::IO_STATUS_OFFSET: begin
                rd[bscr_pkg::IO_BASE_CAP_LSB +: 2] =
                    bscr_pkg::IO_32BIT_CODE;
                rd[bscr_pkg::IO_LIMIT_CAP_LSB +: 2] =
                    bscr_pkg::IO_32BIT_CODE;
                rd[bscr_pkg::IO_BASE_LSB +: 4] = r.io_base;
                rd[bscr_pkg::IO_LIMIT_LSB +: 4] = r.io_limit;
                rd[bscr_pkg::CAP_66MHZ_BIT] = 1'b1;
                rd[bscr_pkg::FAST_B2B_BIT] = !reverse && parallel;
                rd[bscr_pkg::MDPE_BIT] = r.mdpe;
            end
            bscr_pkg::INT_STATUS_OFFSET: begin
                rd[bscr_pkg::NUM_EVENTS-1:0] = r.int_status;
            end
            bscr_pkg::INT_MASK_OFFSET: begin
                rd[bscr_pkg::NUM_EVENTS-1:0] = r.int_mask;
            end
            bscr_pkg::CONTROL_OFFSET: begin
                rd[2:0] = r.control;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (r.aw_addr)
            bscr_pkg::BUS_NUM_OFFSET,
            bscr_pkg::IO_STATUS_OFFSET,
            bscr_pkg::INT_MASK_OFFSET,
            bscr_pkg::CONTROL_OFFSET: wr_hit = 1'b1;
            // status clears by read only; writes are accepted and dropped
            bscr_pkg::INT_STATUS_OFFSET: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_r = r;
        wd = r.w_data;
        do_write = r.aw_got && r.w_got && !r.bvalid;
        do_read = S_AXI_ARVALID && !r.rvalid;

        if (S_AXI_AWVALID && !r.aw_got) begin
            next_r.aw_got = 1'b1;
            next_r.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !r.w_got) begin
            next_r.w_got = 1'b1;
            next_r.w_data = S_AXI_WDATA;
            next_r.w_strb = S_AXI_WSTRB;
        end
        // address and data stay held until the response is taken
        if (r.bvalid && S_AXI_BREADY) begin
            next_r.bvalid = 1'b0;
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
        end
        if (r.rvalid && S_AXI_RREADY) begin
            next_r.rvalid = 1'b0;
        end

        if (do_write) begin
            next_r.bvalid = 1'b1;
            next_r.bresp = wr_hit ? bscr_pkg::RESP_OKAY
                : bscr_pkg::RESP_SLVERR;
            case (r.aw_addr)
                bscr_pkg::BUS_NUM_OFFSET: begin
                    if (r.w_strb[1]) begin
                        next_r.sec_bus = wd[15:8];
                    end
                    if (r.w_strb[2]) begin
                        next_r.high_bus = wd[23:16];
                    end
                    if (r.w_strb[3] && !reverse && parallel) begin
                        next_r.lat_timer = wd[31:24];
                    end
                end
                bscr_pkg::IO_STATUS_OFFSET: begin
                    if (r.w_strb[0]) begin
                        next_r.io_base = wd[7:4];
                    end
                    if (r.w_strb[1]) begin
                        next_r.io_limit = wd[15:12];
                    end
                    if (r.w_strb[3] && wd[bscr_pkg::MDPE_BIT]) begin
                        next_r.mdpe = 1'b0;
                    end
                end
                bscr_pkg::INT_MASK_OFFSET: begin
                    if (r.w_strb[0]) begin
                        next_r.int_mask = wd[bscr_pkg::NUM_EVENTS-1:0];
                    end
                end
                bscr_pkg::CONTROL_OFFSET: begin
                    if (r.w_strb[0]) begin
                        next_r.control = wd[2:0];
                    end
                end
                default: begin
                end
            endcase
        end

        if (do_read) begin
            next_r.rvalid = 1'b1;
            next_r.rdata = rd;
            next_r.rresp = rd_hit ? bscr_pkg::RESP_OKAY
                : bscr_pkg::RESP_SLVERR;
            if (S_AXI_ARADDR == bscr_pkg::INT_STATUS_OFFSET) begin
                next_r.int_status = '0;
            end
        end

        // reverse mode forces the timer to zero whatever was written
        // forced in the same cycle the mode write lands
        if (next_r.control[bscr_pkg::CTRL_REVERSE_BIT]) begin
            next_r.lat_timer = bscr_pkg::BYTE_RESET;
        end
        if (any_set) begin
            next_r.mdpe = 1'b1;
        end
        // set after clear so an event in the read cycle survives
        next_r.int_status = next_r.int_status | (perr_en ? ev : '0);
        next_r.irq = |(next_r.int_status & next_r.int_mask);
        // readies kept as flops so the bus outputs carry no logic
        next_r.aw_ready = !next_r.aw_got;
        next_r.w_ready = !next_r.w_got;
        next_r.ar_ready = !next_r.rvalid;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (RESET) begin
            r <= '0;
            r.sec_bus <= bscr_pkg::BYTE_RESET;
            r.high_bus <= bscr_pkg::BYTE_RESET;
            r.lat_timer <= bscr_pkg::BYTE_RESET;
            r.io_base <= bscr_pkg::WINDOW_RESET;
            r.io_limit <= bscr_pkg::WINDOW_RESET;
            r.mdpe <= 1'b0;
            r.control <= bscr_pkg::CONTROL_RESET;
            r.aw_ready <= 1'b1;
            r.w_ready <= 1'b1;
            r.ar_ready <= 1'b1;
        end else if (CLK_EN) begin
            r <= next_r;
        end
    end

    assign S_AXI_AWREADY = r.aw_ready;
    assign S_AXI_WREADY = r.w_ready;
    assign S_AXI_BVALID = r.bvalid;
    assign S_AXI_BRESP = r.bresp;
    assign S_AXI_ARREADY = r.ar_ready;
    assign S_AXI_RVALID = r.rvalid;
    assign S_AXI_RDATA = r.rdata;
    assign S_AXI_RRESP = r.rresp;
    assign SECONDARY_BUS_NUMBER = r.sec_bus;
    assign HIGHEST_DOWNSTREAM_BUS = r.high_bus;
    assign SECONDARY_LATENCY_TIMER = r.lat_timer;
    assign IO_WINDOW_BASE = r.io_base;
    assign IO_WINDOW_LIMIT = r.io_limit;
    assign MASTER_PARITY_ERROR = r.mdpe;
    assign IRQ = r.irq;
endmodule : bscr_regs

/* File: bench/bscr_properties.sv */
module bscr_properties (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [7:0] SECONDARY_LATENCY_TIMER,
    input wire logic MASTER_PARITY_ERROR,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    sequence s_wr_taken;
        CLK_EN && S_AXI_AWVALID && S_AXI_AWREADY
            && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    // register change must come from a write being answered
    sequence s_answered;
        ##[0:1] S_AXI_BVALID;
    endsequence
    property p_wr_answer;
        s_wr_taken ##1 CLK_EN |=> S_AXI_BVALID;
    endproperty
    property p_rd_answer;
        CLK_EN && S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
    endproperty
    property p_rd_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    property p_ar_block;
        S_AXI_RVALID |-> !S_AXI_ARREADY;
    endproperty
    property p_wr_block;
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    property p_after_reset;
        $past(RESET) |-> SECONDARY_LATENCY_TIMER == 8'h00
            && !MASTER_PARITY_ERROR && !IRQ;
    endproperty
    property p_mdpe_clear;
        $fell(MASTER_PARITY_ERROR) && !$past(RESET) |-> s_answered;
    endproperty
    property p_timer_change;
        !$stable(SECONDARY_LATENCY_TIMER) && !$past(RESET) |-> s_answered;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("no bvalid");
    a_rd_answer: assert property (p_rd_answer) else $error("no rvalid");
    a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
    a_ar_block: assert property (p_ar_block) else $error("arready high");
    a_wr_block: assert property (p_wr_block) else $error("wready high");
    a_after_reset: assert property (p_after_reset)
        else $error("bad reset value");
    a_mdpe_clear: assert property (p_mdpe_clear)
        else $error("flag dropped");
    a_timer_change: assert property (p_timer_change)
        else $error("timer moved");
endmodule : bscr_properties
bind bscr_regs bscr_properties bscr_properties_i (.CLK, .RESET, .CLK_EN,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
    .S_AXI_RREADY, .S_AXI_RDATA, .SECONDARY_LATENCY_TIMER,
    .MASTER_PARITY_ERROR, .IRQ);

/* File: bench/bscr_regs_bench.sv */
module bscr_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK = bscr_pkg::RESP_OKAY;
    localparam logic [1:0] ER = bscr_pkg::RESP_SLVERR;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00, sb, hb, lat;
    logic [31:0] wd = 32'h0, rdata;
    logic [3:0] ws = 4'h0, iob, iol;
    logic [4:0] ev = 5'h00;
    logic awr, wry, bv, arr, rv, mdpe, irq;
    logic [1:0] bresp, rresp;
    int n_fail = 0, checked = 0, i;
    always #2 clk = ~clk;
    // bit 1 of ev is the parity pin, pulled low during a write phase
    bscr_regs bscr_regs_i (.CLK(clk), .RESET(reset), .CLK_EN(ce),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wry), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
        .READ_DATA_PARITY_ERROR(ev[0]), .WRITE_PHASE_ACTIVE(ev[1]),
        .DOWNSTREAM_PARITY_ERROR_N(!ev[1]), .SPLIT_MSG_PARITY_ERROR(ev[2]),
        .POISONED_COMPLETION(ev[3]), .POISONED_WRITE_FORWARDED(ev[4]),
        .SECONDARY_BUS_NUMBER(sb), .HIGHEST_DOWNSTREAM_BUS(hb),
        .SECONDARY_LATENCY_TIMER(lat), .IO_WINDOW_BASE(iob),
        .IO_WINDOW_LIMIT(iol), .MASTER_PARITY_ERROR(mdpe), .IRQ(irq));
    task tally_and_finish;
        $display("checks %0d errors %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task stall;
        n_fail++;
        $display("[ERR] %0t bus timeout", $time);
        tally_and_finish();
    endtask : stall
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        int k;
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge clk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(negedge clk);
            ta = awv && awr;
            tw = wv && wry;
            tb = bv;
            r = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) begin
                bry <= 1'b0;
                break;
            end
        end
        if (k == 64) stall();
        chk(32'(r), 32'(er));
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        logic tt, tv;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(negedge clk);
            tt = arv && arr;
            tv = rv;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (tt) arv <= 1'b0;
            if (tv) begin
                rry <= 1'b0;
                break;
            end
        end
        if (k == 64) stall();
        chk(d, ed);
        chk(32'(r), 32'(er));
    endtask : rd
    task pulse(input int n, input logic em, input logic ei);
        @(posedge clk);
        ev <= 5'(1 << n);
        @(posedge clk);
        ev <= 5'h00;
        repeat (2) @(negedge clk);
        chk(32'(mdpe), 32'(em));
        chk(32'(irq), 32'(ei));
    endtask : pulse
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(8'h18, 32'h0, OK);
        rd(8'h1c, 32'h00a00101, OK);
        wr(8'h18, 32'haabbcc55, 4'hf, OK);
        wr(8'h18, 32'h11223344, 4'h2, OK);
        rd(8'h18, 32'haabb3300, OK);
        chk(32'({lat, hb, sb}), 32'haabb33);
        wr(8'h1c, 32'hffffffff, 4'h3, OK);
        rd(8'h1c, 32'h00a0f1f1, OK);
        chk(32'({iol, iob}), 32'hff);
        pulse(0, 1'b0, 1'b0);
        rd(8'h40, 32'h0, OK);
        wr(8'h48, 32'h6, 4'hf, OK);
        for (i = 0; i < 5; i++) begin
            if (i == 3) wr(8'h48, 32'h7, 4'hf, OK);
            wr(8'h44, (i == 0) ? 32'h0 : 32'h1f, 4'hf, OK);
            pulse(i, 1'b1, i != 0);
            rd(8'h40, 32'(1 << i), OK);
            repeat (2) @(negedge clk);
            chk(32'(irq), 32'h0);
            wr(8'h1c, 32'h0, 4'h8, OK);
            @(negedge clk);
            chk(32'(mdpe), 32'h1);
            wr(8'h1c, 32'h01000000, 4'h8, OK);
            @(negedge clk);
            chk(32'(mdpe), 32'h0);
        end
        wr(8'h18, 32'hff000000, 4'h8, OK);
        rd(8'h18, 32'h00bb3300, OK);
        rd(8'h1c, 32'h0020f1f1, OK);
        pulse(0, 1'b0, 1'b0);
        // frozen clock enable: the event must be missed
        @(posedge clk);
        ce <= 1'b0;
        pulse(3, 1'b0, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        rd(8'h40, 32'h0, OK);
        wr(8'h48, 32'h4, 4'hf, OK);
        wr(8'h18, 32'hff000000, 4'h8, OK);
        rd(8'h18, 32'h00bb3300, OK);
        rd(8'h1c, 32'h0020f1f1, OK);
        rd(8'h80, 32'h0, ER);
        wr(8'h84, 32'h5a, 4'hf, ER);
        // second reset in mid-run brings every field back
        @(posedge clk);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(8'h18, 32'h0, OK);
        rd(8'h1c, 32'h00a00101, OK);
        chk(32'({iol, iob}), 32'h0);
        chk(32'({lat, hb, sb}), 32'h0);
        tally_and_finish();
    end
endmodule : bscr_regs_bench
